// ### rtl/swmc_top.sv
// sleep, wake-up and mode control of a single-wire bus transceiver
//
// Overview of operation
// (R1) regulator enable is low whenever the device sleeps
// (R2) a filtered high-voltage wake-up takes the device out of sleep, regulator on
// (R3) microcontroller must select a non-sleep mode or the regulator drops again
// (R4) regulator stays on for the hold delay after wake-up signalling ends
// (R5) with both mode pins low, sleep returns after the hold even under wake-up
// (R6) a 500 kHz tick clocks all timers
// (R7) driver stays active for a programmable period after a recessive edge
// (R8) receiver yields bus data and flags wake-up to mode control and timers
// (R9) wake-up flag is deglitched before it is acted on
// (R10) high-voltage drive only when mode allows; no waveshaping in high-speed mode
// (R11) under-voltage disables receiver and driver
// (R12) load switch opens when module ground is lost
// (R13) mode pins: 00 sleep, 01 wake-up, 10 high speed, 11 normal
// (R14) mode pins have weak pull-downs so undriven pins mean sleep
// (R15) bus is the inverse of transmit data: low drives dominant
// (R16) asleep, receive output is off unless wake-up level present
// (R17) hold delays are tick counters restarted on each new start condition
`timescale 1ns/100ps
module swmc_top
    import swmc_pkg::*;
#(
    parameter logic [SWMC_HOLD_W-1:0] HOLD_TICKS = SWMC_HOLD_W'(SWMC_HOLD_TICKS_DEF),
    parameter logic [SWMC_FILT_W-1:0] FILT_TICKS = SWMC_FILT_W'(SWMC_WAKE_FILT_TICKS)
) (
    // clock and reset
    input  wire logic                    CLK_SYS,
    input  wire logic                    RST_B,
    // microcontroller side pins
    input  wire logic                    MODE_SELECT_LO,
    input  wire logic                    MODE_SELECT_HI,
    input  wire logic                    TXD,
    output logic                         RXD_OUT,
    output logic                         RXD_OE,
    output logic                         REGULATOR_ENABLE_OUT,
    output logic                         MODE_PULLDOWN_ON,
    // bus side: comparator and monitor levels in
    input  wire logic                    BUS_DOMINANT_IN,
    input  wire logic                    HIGH_VOLTAGE_WAKEUP_IN,
    input  wire logic                    UNDER_VOLTAGE_IN,
    input  wire logic                    GROUND_LOST_IN,
    // bus side: driver controls out
    output logic                         BUS_DRIVE_DOMINANT,
    output logic                         BUS_HV_DRIVE_EN,
    output logic                         BUS_WAVESHAPE_EN,
    output logic                         BUS_DRIVER_ACTIVE,
    output logic                         LOAD_SWITCH_ON,
    // register port
    input  wire logic [SWMC_ADDR_W-1:0]  REG_ADDR,
    input  wire logic [SWMC_DATA_W-1:0]  REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic      [SWMC_DATA_W-1:0]  REG_RDATA
);

    localparam logic [SWMC_DIV_W-1:0]  DIV_LAST  = SWMC_DIV_W'(SWMC_OSC_DIV - 1);
    localparam logic [SWMC_HOLD_W-1:0] HOLD_LAST = HOLD_TICKS - 1'b1;

    function automatic logic is_sleep(input swmc_mode_t m);
        return m == SWMC_MODE_SLEEP;
    endfunction

    // ---------------- input synchronisation
    swmc_pins_t pins_raw;
    swmc_pins_t pins_s;

    always_comb begin
        pins_raw                     = SWMC_PINS_RST;
        pins_raw.mode_select_lo      = MODE_SELECT_LO;
        pins_raw.mode_select_hi      = MODE_SELECT_HI;
        pins_raw.txd                 = TXD;
        pins_raw.bus_dominant        = BUS_DOMINANT_IN;
        pins_raw.high_voltage_wakeup = HIGH_VOLTAGE_WAKEUP_IN;
        pins_raw.under_voltage       = UNDER_VOLTAGE_IN;
        pins_raw.ground_lost         = GROUND_LOST_IN;
    end

    swmc_sync #(
        .W       ($bits(swmc_pins_t)),
        .RST_VAL (SWMC_PINS_RST)
    ) u_sync (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .d_in  (pins_raw),
        .q_out (pins_s)
    );

    swmc_mode_t mode;
    assign mode = swmc_mode_t'({pins_s.mode_select_lo, pins_s.mode_select_hi}); // see (R13)

    // ---------------- internal oscillator tick
    logic [SWMC_DIV_W-1:0] div_r;
    logic [SWMC_DIV_W-1:0] div_nxt;
    logic                  tick;

    always_comb begin
        tick    = (div_r == DIV_LAST); // see (R6)
        div_nxt = tick ? '0 : div_r + 1'b1;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // ---------------- wake-up deglitch
    // filtered level only moves after the raw level has held for FILT_TICKS
    logic                   wake_r;
    logic                   wake_nxt;
    logic [SWMC_FILT_W-1:0] filt_r;
    logic [SWMC_FILT_W-1:0] filt_nxt;
    logic                   wake_rise;
    logic                   wake_fall;

    always_comb begin
        wake_nxt = wake_r;
        filt_nxt = filt_r;
        if (pins_s.high_voltage_wakeup == wake_r) begin
            filt_nxt = '0; // see (R9)
        end else if (tick) begin
            if (filt_r >= FILT_TICKS - 1'b1) begin
                wake_nxt = pins_s.high_voltage_wakeup;
                filt_nxt = '0;
            end else begin
                filt_nxt = filt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            wake_r <= 1'b0;
            filt_r <= '0;
        end else begin
            wake_r <= wake_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign wake_rise = wake_nxt & ~wake_r; // see (R8)
    assign wake_fall = ~wake_nxt & wake_r;

    // ---------------- mode control and regulator hold
    swmc_state_t            state_r;
    swmc_state_t            state_nxt;
    logic [SWMC_HOLD_W-1:0] hold_r;
    logic [SWMC_HOLD_W-1:0] hold_nxt;
    logic                   hold_done;

    assign hold_done = tick && (hold_r == HOLD_LAST);

    always_comb begin
        state_nxt = state_r;
        hold_nxt  = hold_r;
        case (state_r)
            SWMC_SLEEP: begin
                hold_nxt = '0;
                // only a fresh wake edge leaves sleep, so a lingering level cannot loop
                if (wake_rise) begin
                    state_nxt = SWMC_HOLD; // see (R2)
                end
            end
            SWMC_HOLD: begin
                if (!is_sleep(mode)) begin
                    state_nxt = SWMC_ACTIVE; // see (R3)
                    hold_nxt  = '0;
                end else if (wake_fall) begin
                    hold_nxt = '0; // see (R4) (R17)
                end else if (hold_done) begin
                    state_nxt = SWMC_SLEEP; // see (R5)
                    hold_nxt  = '0;
                end else if (tick) begin
                    hold_nxt = hold_r + 1'b1;
                end
            end
            SWMC_ACTIVE: begin
                hold_nxt = '0;
                if (is_sleep(mode)) begin
                    state_nxt = SWMC_HOLD; // see (R17)
                end
            end
            default: begin
                state_nxt = SWMC_SLEEP;
                hold_nxt  = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= SWMC_SLEEP;
            hold_r  <= '0;
        end else begin
            state_r <= state_nxt;
            hold_r  <= hold_nxt;
        end
    end

    // ---------------- transmit driver hold timer
    logic [SWMC_TXH_W-1:0] txhold_cfg_r;
    logic [SWMC_TXH_W-1:0] txhold_cfg_nxt;
    logic [SWMC_TXH_W-1:0] txcnt_r;
    logic [SWMC_TXH_W-1:0] txcnt_nxt;
    logic                  drive_ok;
    logic                  dom_req;

    // under-voltage and sleep both mute the driver
    assign drive_ok = !pins_s.under_voltage && (state_nxt != SWMC_SLEEP); // see (R11)
    assign dom_req  = drive_ok && !pins_s.txd; // see (R15)

    always_comb begin
        txcnt_nxt = txcnt_r;
        if (dom_req || !drive_ok) begin
            txcnt_nxt = '0;
        end else if (BUS_DRIVE_DOMINANT) begin
            txcnt_nxt = txhold_cfg_r; // see (R7)
        end else if (tick && txcnt_r != '0) begin
            txcnt_nxt = txcnt_r - 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            txcnt_r <= '0;
        end else begin
            txcnt_r <= txcnt_nxt;
        end
    end

    // ---------------- registered pin outputs
    logic reg_en_r;
    logic dom_r;
    logic hv_r;
    logic shape_r;
    logic act_r;
    logic rxd_oe_r;
    logic load_r;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            reg_en_r <= 1'b0;
            dom_r    <= 1'b0;
            hv_r     <= 1'b0;
            shape_r  <= 1'b0;
            act_r    <= 1'b0;
            rxd_oe_r <= 1'b0;
            load_r   <= 1'b1;
        end else begin
            reg_en_r <= (state_nxt != SWMC_SLEEP); // see (R1) (R2)
            dom_r    <= dom_req;
            hv_r     <= drive_ok && (mode == SWMC_MODE_HVWAKE); // see (R10)
            shape_r  <= drive_ok && (mode != SWMC_MODE_HSPEED); // see (R10)
            act_r    <= dom_req || (txcnt_nxt != '0); // see (R7)
            // open drain: pull low on dominant bus when awake or under wake-up
            rxd_oe_r <= !pins_s.under_voltage && pins_s.bus_dominant
                        && (state_nxt != SWMC_SLEEP || wake_nxt); // see (R8) (R11) (R16)
            load_r   <= !pins_s.ground_lost; // see (R12)
        end
    end

    assign REGULATOR_ENABLE_OUT = reg_en_r;
    assign BUS_DRIVE_DOMINANT   = dom_r;
    assign BUS_HV_DRIVE_EN      = hv_r;
    assign BUS_WAVESHAPE_EN     = shape_r;
    assign BUS_DRIVER_ACTIVE    = act_r;
    assign RXD_OE               = rxd_oe_r;
    assign RXD_OUT              = 1'b0;
    assign LOAD_SWITCH_ON       = load_r;
    // weak pull-downs are always present on the mode pins
    assign MODE_PULLDOWN_ON     = 1'b1; // see (R14)

    // ---------------- register port
    logic [SWMC_DATA_W-1:0] rdata_r;
    logic [SWMC_DATA_W-1:0] rdata_nxt;
    logic [SWMC_DATA_W-1:0] status;

    always_comb begin
        status                   = '0;
        status[SWMC_ST_REG_EN]   = reg_en_r;
        status[SWMC_ST_MODE_LO]  = pins_s.mode_select_lo;
        status[SWMC_ST_MODE_HI]  = pins_s.mode_select_hi;
        status[SWMC_ST_WAKE]     = wake_r;
        status[SWMC_ST_UV]       = pins_s.under_voltage;
        status[SWMC_ST_GND_LOST] = pins_s.ground_lost;
        status[SWMC_ST_ASLEEP]   = (state_r == SWMC_SLEEP);
        status[SWMC_ST_DRV_ACT]  = act_r;
    end

    always_comb begin
        txhold_cfg_nxt = txhold_cfg_r;
        rdata_nxt      = '0;
        if (REG_WR && REG_ADDR == SWMC_REG_TXHOLD) begin
            txhold_cfg_nxt = REG_WDATA[SWMC_TXH_W-1:0];
        end
        if (REG_RD) begin
            case (REG_ADDR)
                SWMC_REG_STATUS: rdata_nxt = status;
                SWMC_REG_TXHOLD: rdata_nxt = {{(SWMC_DATA_W-SWMC_TXH_W){1'b0}}, txhold_cfg_r};
                default:         rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            txhold_cfg_r <= SWMC_TXHOLD_RST;
            rdata_r      <= '0;
        end else begin
            txhold_cfg_r <= txhold_cfg_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;

    // ---------------- assertions
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    a_sleep_reg_low: assert property ( // see (R1)
        state_r == SWMC_SLEEP |-> !REGULATOR_ENABLE_OUT)
        else $error("regulator enable high while asleep");

    a_wake_reg_high: assert property ( // see (R2)
        state_r == SWMC_SLEEP && wake_rise |=> REGULATOR_ENABLE_OUT && state_r == SWMC_HOLD)
        else $error("wake-up did not raise regulator enable");

    a_hold_full_count: assert property ( // see (R4)
        $fell(REGULATOR_ENABLE_OUT) |-> $past(hold_r) == HOLD_LAST && $past(tick))
        else $error("regulator dropped before hold expired");

    a_hold_under_wake: assert property ( // see (R5)
        state_r == SWMC_HOLD && is_sleep(mode) && !wake_fall && hold_done
        |=> state_r == SWMC_SLEEP ##1 !REGULATOR_ENABLE_OUT)
        else $error("no return to sleep after hold");

    a_tick_spacing: assert property ( // see (R6)
        tick |=> !tick [*8])
        else $error("oscillator tick too frequent");

    a_txd_hold_active: assert property ( // see (R7)
        $fell(BUS_DRIVE_DOMINANT) && drive_ok && txhold_cfg_r != '0 |-> BUS_DRIVER_ACTIVE)
        else $error("driver released on recessive edge");

    a_uv_mutes_all: assert property ( // see (R11)
        pins_s.under_voltage |=> !BUS_DRIVE_DOMINANT && !RXD_OE && !BUS_HV_DRIVE_EN)
        else $error("driver or receiver active in under-voltage");

    a_gnd_lost_open: assert property ( // see (R12)
        pins_s.ground_lost |=> !LOAD_SWITCH_ON)
        else $error("load switch closed with ground lost");

    a_hs_no_shape: assert property ( // see (R10)
        mode == SWMC_MODE_HSPEED |=> !BUS_WAVESHAPE_EN && !BUS_HV_DRIVE_EN)
        else $error("waveshaping or high voltage in high-speed mode");

    a_rxd_off_asleep: assert property ( // see (R16)
        state_nxt == SWMC_SLEEP && !wake_nxt |=> !RXD_OE)
        else $error("receive output on while asleep");

    c_wake_up:      cover property (state_r == SWMC_SLEEP ##1 state_r == SWMC_HOLD);
    c_go_active:    cover property (state_r == SWMC_HOLD ##1 state_r == SWMC_ACTIVE);
    c_hold_expire:  cover property (state_r == SWMC_HOLD ##1 state_r == SWMC_SLEEP);
    c_txd_hold_end: cover property ($fell(BUS_DRIVER_ACTIVE));

endmodule // swmc_top

// ### include/swmc_pkg.sv
// constants, types and pin bundle of the sleep and wake-up mode control
package swmc_pkg;

    // timebase
    localparam int unsigned SWMC_CLK_HZ      = 50_000_000;
    localparam int unsigned SWMC_OSC_HZ      = 500_000;
    localparam int unsigned SWMC_OSC_DIV     = SWMC_CLK_HZ / SWMC_OSC_HZ;
    localparam int unsigned SWMC_DIV_W       = 7;

    // regulator hold: least time, rounded up to whole oscillator ticks
    localparam int unsigned SWMC_HOLD_MS     = 300;
    localparam int unsigned SWMC_HOLD_TICKS_DEF =
        (SWMC_HOLD_MS * SWMC_OSC_HZ + 999) / 1000;
    localparam int unsigned SWMC_HOLD_W      = 20;

    // wake-up deglitch: least time, rounded up
    localparam int unsigned SWMC_WAKE_FILT_US    = 10;
    localparam int unsigned SWMC_WAKE_FILT_TICKS =
        (SWMC_WAKE_FILT_US * SWMC_OSC_HZ + 999_999) / 1_000_000;
    localparam int unsigned SWMC_FILT_W      = 8;

    // transmit driver hold after a recessive edge
    localparam int unsigned SWMC_TXD_HOLD_US     = 32;
    localparam int unsigned SWMC_TXD_HOLD_TICKS  =
        (SWMC_TXD_HOLD_US * SWMC_OSC_HZ + 999_999) / 1_000_000;
    localparam int unsigned SWMC_TXH_W       = 8;

    // register port
    localparam int unsigned SWMC_ADDR_W      = 4;
    localparam int unsigned SWMC_DATA_W      = 32;
    localparam logic [SWMC_ADDR_W-1:0] SWMC_REG_STATUS = 4'h0;
    localparam logic [SWMC_ADDR_W-1:0] SWMC_REG_TXHOLD = 4'h4;
    localparam logic [SWMC_TXH_W-1:0]  SWMC_TXHOLD_RST = 8'h10;

    // status field positions
    localparam int unsigned SWMC_ST_REG_EN   = 0;
    localparam int unsigned SWMC_ST_MODE_LO  = 1;
    localparam int unsigned SWMC_ST_MODE_HI  = 2;
    localparam int unsigned SWMC_ST_WAKE     = 3;
    localparam int unsigned SWMC_ST_UV       = 4;
    localparam int unsigned SWMC_ST_GND_LOST = 5;
    localparam int unsigned SWMC_ST_ASLEEP   = 6;
    localparam int unsigned SWMC_ST_DRV_ACT  = 7;

    // mode pins as {mode_select_lo, mode_select_hi}
    typedef enum logic [1:0] {
        SWMC_MODE_SLEEP  = 2'h0,
        SWMC_MODE_HVWAKE = 2'h1,
        SWMC_MODE_HSPEED = 2'h2,
        SWMC_MODE_NORMAL = 2'h3
    } swmc_mode_t;

    typedef enum logic [1:0] {
        SWMC_SLEEP,
        SWMC_HOLD,
        SWMC_ACTIVE
    } swmc_state_t;

    // pins and monitor levels that cross into the clock domain
    typedef struct packed {
        logic mode_select_lo;
        logic mode_select_hi;
        logic txd;
        logic bus_dominant;
        logic high_voltage_wakeup;
        logic under_voltage;
        logic ground_lost;
    } swmc_pins_t;

    localparam swmc_pins_t SWMC_PINS_RST = '{
        mode_select_lo:      1'b0,
        mode_select_hi:      1'b0,
        txd:                 1'b1,
        bus_dominant:        1'b0,
        high_voltage_wakeup: 1'b0,
        under_voltage:       1'b1,
        ground_lost:         1'b0
    };

endpackage

// ### rtl/swmc_sync.sv
// three-stage input synchroniser with agreement check
`timescale 1ns/100ps
module swmc_sync #(
    parameter int unsigned W                = 1,
    parameter logic [W-1:0] RST_VAL         = '0
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst_b,
    // asynchronous levels in, settled levels out
    input  wire logic [W-1:0]   d_in,
    output logic      [W-1:0]   q_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic s2_r;
            logic s3_r;
            logic q_r;
            logic q_nxt;

            // stage one feeds stage two only
            always_comb begin
                q_nxt = (s2_r == s3_r) ? s3_r : q_r;
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_r <= RST_VAL[i];
                    s2_r   <= RST_VAL[i];
                    s3_r   <= RST_VAL[i];
                    q_r    <= RST_VAL[i];
                end else begin
                    meta_r <= d_in[i];
                    s2_r   <= meta_r;
                    s3_r   <= s2_r;
                    q_r    <= q_nxt;
                end
            end

            assign q_out[i] = q_r;
        end
    endgenerate

endmodule // swmc_sync

// ### verif/swmc_mcu.sv
// microcontroller model that is powered by the regulator output and drives the mode pins
`timescale 1ns/100ps
module swmc_mcu
    import swmc_pkg::*;
(
    // clock
    input  wire logic        clk,
    // power and pin pull-down from the transceiver
    input  wire logic        power_on,
    input  wire logic        pulldown_on,
    // wanted mode and boot time from the bench
    input  wire swmc_mode_t  want_mode,
    input  wire logic [15:0] boot_cyc,
    // mode pins
    output logic             mode_lo,
    output logic             mode_hi
);
    logic [15:0] boot_r  = '0;
    logic        drive_r = 1'b0;
    logic        tgl_r   = 1'b0;

    always @(posedge clk) begin
        tgl_r <= !tgl_r;
        if (!power_on) begin
            boot_r  <= '0;
            drive_r <= 1'b0;
        end else if (boot_r < boot_cyc) begin
            boot_r <= boot_r + 16'h1;
        end else begin
            drive_r <= 1'b1;
        end
    end

    // unpowered pins fall to the pull-down; without it they are undefined
    assign mode_lo = drive_r ? want_mode[1] : (pulldown_on ? 1'b0 : tgl_r);
    assign mode_hi = drive_r ? want_mode[0] : (pulldown_on ? 1'b0 : !tgl_r);
endmodule // swmc_mcu

// ### verif/swmc_top_tb.sv
// self-checking bench of the sleep and wake-up mode control
`timescale 1ns/100ps
module swmc_top_tb;
    import swmc_pkg::*;
    localparam int HT = 8;
    localparam int TK = SWMC_OSC_DIV;
    logic CLK_SYS = 1'b0;
    logic RST_B   = 1'b0;
    logic txd = 1'b1, ext_dom = 1'b0, hvw = 1'b0, uv = 1'b0, gl = 1'b0;
    logic wr = 1'b0, rd = 1'b0;
    logic [SWMC_ADDR_W-1:0] addr  = '0;
    logic [SWMC_DATA_W-1:0] wdata = '0;
    logic [SWMC_DATA_W-1:0] rdata;
    logic rxd_out, rxd_oe, reg_en, pd_on, drv_dom, hv_en, shape_en, drv_act, load_on;
    logic mlo, mhi;
    logic [3:0]  obs;
    swmc_mode_t  want = SWMC_MODE_SLEEP;
    logic [15:0] boot = 16'h0003;
    logic [31:0] exp_q[$];
    logic        rd_d = 1'b0;
    logic [7:0]  lf = 8'h3e;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;

    always #10 CLK_SYS = !CLK_SYS;
    assign obs = {rxd_oe, load_on, drv_act, reg_en};

    swmc_top #(.HOLD_TICKS(20'(HT)), .FILT_TICKS(8'h2)) dut (
        .CLK_SYS                (CLK_SYS),
        .RST_B                  (RST_B),
        .MODE_SELECT_LO         (mlo),
        .MODE_SELECT_HI         (mhi),
        .TXD                    (txd),
        .RXD_OUT                (rxd_out),
        .RXD_OE                 (rxd_oe),
        .REGULATOR_ENABLE_OUT   (reg_en),
        .MODE_PULLDOWN_ON       (pd_on),
        .BUS_DOMINANT_IN        (drv_dom | ext_dom),
        .HIGH_VOLTAGE_WAKEUP_IN (hvw),
        .UNDER_VOLTAGE_IN       (uv),
        .GROUND_LOST_IN         (gl),
        .BUS_DRIVE_DOMINANT     (drv_dom),
        .BUS_HV_DRIVE_EN        (hv_en),
        .BUS_WAVESHAPE_EN       (shape_en),
        .BUS_DRIVER_ACTIVE      (drv_act),
        .LOAD_SWITCH_ON         (load_on),
        .REG_ADDR               (addr),
        .REG_WDATA              (wdata),
        .REG_WR                 (wr),
        .REG_RD                 (rd),
        .REG_RDATA              (rdata)
    );

    swmc_mcu mcu (
        .clk         (CLK_SYS),
        .power_on    (reg_en),
        .pulldown_on (pd_on),
        .want_mode   (want),
        .boot_cyc    (boot),
        .mode_lo     (mlo),
        .mode_hi     (mhi)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic summarize;
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic win(input string what, input int n, input int lo, input int hi);
        check(what, 32'(n >= lo && n <= hi), 32'h1);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask

    // bounded wait on one watched output, returns cycles spent
    task automatic wait_obs(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (obs[k] !== v && n < lim) begin
            @(posedge CLK_SYS);
            n++;
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge CLK_SYS);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge CLK_SYS);
        addr <= a;
        rd   <= 1'b1;
        @(posedge CLK_SYS);
        rd <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge CLK_SYS) begin
        rd_d <= rd;
        if (rd_d)
            check("rdata", rdata, exp_q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    initial begin : main
        int n;
        int v;
        repeat (8) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        tick(6);
        check("reg_en", reg_en, 1'b0);
        check("load", load_on, 1'b1);
        check("pulldown", pd_on, 1'b1);
        check("rxd level", rxd_out, 1'b0);
        reg_rd(SWMC_REG_STATUS, 32'h40);
        reg_rd(SWMC_REG_TXHOLD, 32'h10);
        reg_rd(4'h8, 32'h0);
        // a pulse shorter than one tick must be ignored
        @(posedge CLK_SYS);
        hvw <= 1'b1;
        tick(TK / 2);
        hvw <= 1'b0;
        tick(4 * TK);
        check("glitch", reg_en, 1'b0);
        // slow controller: sleep returns under a standing wake level
        @(posedge CLK_SYS);
        boot <= 16'hffff;
        hvw  <= 1'b1;
        wait_obs(0, 1'b1, 4 * TK, n);
        win("wake", n, 1, 4 * TK - 1);
        reg_rd(SWMC_REG_STATUS, 32'h09);
        wait_obs(0, 1'b0, (HT + 2) * TK, n);
        win("hold", n, (HT - 1) * TK, (HT + 1) * TK);
        ext_dom <= 1'b1;
        tick(8);
        check("rx asleep", rxd_oe, 1'b1);
        ext_dom <= 1'b0;
        tick(8);
        check("rx asleep", rxd_oe, 1'b0);
        hvw     <= 1'b0;
        ext_dom <= 1'b1;
        txd     <= 1'b0;
        tick(4 * TK);
        check("rx off", rxd_oe, 1'b0);
        check("drv sleep", drv_dom, 1'b0);
        ext_dom <= 1'b0;
        txd     <= 1'b1;
        // prompt controller keeps the regulator on
        @(posedge CLK_SYS);
        boot <= 16'h0003;
        want <= SWMC_MODE_NORMAL;
        hvw  <= 1'b1;
        wait_obs(0, 1'b1, 4 * TK, n);
        tick(3 * TK);
        hvw <= 1'b0;
        tick((HT + 3) * TK);
        check("stay on", reg_en, 1'b1);
        reg_rd(SWMC_REG_STATUS, 32'h07);
        for (int m = 1; m < 4; m++) begin
            @(posedge CLK_SYS);
            want <= swmc_mode_t'(m);
            tick(8);
            check("hv drive", hv_en, m == 1);
            check("shaping", shape_en, m != 2);
        end
        lf = lfsr(lf);
        v = 2 + int'(lf[1:0]);
        reg_wr(SWMC_REG_TXHOLD, 32'(v));
        reg_rd(SWMC_REG_TXHOLD, 32'(v));
        @(posedge CLK_SYS);
        txd <= 1'b0;
        // bus level loops back through the receive synchroniser
        tick(12);
        check("dominant", drv_dom, 1'b1);
        check("rx data", rxd_oe, 1'b1);
        txd <= 1'b1;
        tick(6);
        check("recessive", drv_dom, 1'b0);
        wait_obs(1, 1'b0, (v + 2) * TK, n);
        win("drv hold", n, (v - 1) * TK - 10, (v + 1) * TK);
        for (int i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            @(posedge CLK_SYS);
            txd <= lf[0];
            tick(8);
            check("tx data", drv_dom, !lf[0]);
        end
        // supply and ground monitors
        @(posedge CLK_SYS);
        uv      <= 1'b1;
        txd     <= 1'b0;
        ext_dom <= 1'b1;
        tick(8);
        check("uv drv", drv_dom, 1'b0);
        check("uv rx", rxd_oe, 1'b0);
        uv      <= 1'b0;
        txd     <= 1'b1;
        ext_dom <= 1'b0;
        gl      <= 1'b1;
        tick(8);
        check("gnd lost", load_on, 1'b0);
        gl <= 1'b0;
        tick(8);
        check("gnd back", load_on, 1'b1);
        // a fresh sleep request restarts the full hold
        @(posedge CLK_SYS);
        want <= SWMC_MODE_SLEEP;
        tick(4 * TK);
        want <= SWMC_MODE_NORMAL;
        tick(8);
        want <= SWMC_MODE_SLEEP;
        wait_obs(0, 1'b0, (HT + 2) * TK, n);
        win("rehold", n, (HT - 1) * TK, (HT + 1) * TK);
        tick(8);
        reg_rd(SWMC_REG_STATUS, 32'h40);
        tick(4);
        summarize();
    end
endmodule // swmc_top_tb
